// File: seep_pkg.sv
package seep_pkg;
  // -----------------------------------------------------------------
  // control byte layout
  // -----------------------------------------------------------------
  // device-type code, value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h6;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int BLK_BIT = 1;
  localparam int RW_BIT = 0;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  // -----------------------------------------------------------------
  // array and page geometry
  // -----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_SYS_NS = 5;
  localparam int LINK_NS = 15;
  // quarter of one bus bit; two quarters cover the low time
  localparam int QTR_NS = 650;
  localparam int QTR_CYC = (QTR_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int TWC_MS = 5;
  localparam int TWC_CYC = (TWC_MS * 1000000) / LINK_NS;
  localparam int TMR_W = 19;
  localparam int QTMR_W = 8;
  // -----------------------------------------------------------------
  // state encodings
  // -----------------------------------------------------------------
  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_CTRL = 5'h02,
    D_ADDR = 5'h04,
    D_WDATA = 5'h08,
    D_RDATA = 5'h10
  } seep_dst_e;
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BYTE = 4'h4,
    H_STOP = 4'h8
  } seep_hst_e;
endpackage

// File: seep_if.sv
`timescale 1ns/1ps
interface seep_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // wired-and of both open-drain drivers, pulled high otherwise
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

  modport host(output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// File: seep_dev.sv
`timescale 1ns/1ps
// How it works
// - bus idle means both lines high
// - sda fall with scl high restarts decode
// - sda rise with scl high ends operation
// - master opens with start, closes with stop
// - one bit per pulse, sampled scl high
// - receiver pulls sda low on ninth pulse
// - no acknowledge while write cycle runs
// - control byte: type, two spare, block, direction
// - direction bit one reads, zero writes
// - matching type acknowledged, then read or write
// - second byte loads pointer, stop starts write
// - up to sixteen bytes buffered until stop
// - in a write only low four pointer bits advance, wrapping
// - master keeps page writes inside one page
// - protect input high blocks all writes
// - polling control byte acknowledged once idle
// - current read returns last address plus one
// - master nack then stop ends read
// - address-only write sets pointer, no cycle
// - each byte sent advances pointer, master ack gets next byte
// - master alone drives clock, start, stop
// - reads still served while write protected
module seep_dev #(
  parameter int unsigned WC_CYCLES = seep_pkg::TWC_CYC // write cycle length in link clocks
) (
  input wire logic clk_link, // link sampling clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  seep_if.dev lk, // two-wire bus
  input wire logic wp, // write protect, high blocks writes
  output logic write_busy // internal write cycle running
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    seep_pkg::seep_dst_e st;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [1:0] wp_sync;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic blk;
    logic rd;
    logic acked;
    logic mack;
    logic drv;
    logic armed;
    logic [seep_pkg::ADDR_W-1:0] ptr;
    logic busy;
    logic [seep_pkg::TMR_W-1:0] wtimer;
    logic [seep_pkg::PAGE_BYTES-1:0] pmask;
    logic [seep_pkg::PAGE_BYTES-1:0][7:0] pbuf;
    logic [seep_pkg::MEM_DEPTH-1:0][7:0] mem;
  } seep_dev_s;

  seep_dev_s cur;
  seep_dev_s next_cur;
  logic scl_now;
  logic scl_was;
  logic sda_now;
  logic sda_was;
  logic wp_now;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;

  function automatic logic rising(input logic now_v, input logic was_v);
    rising = now_v & ~was_v;
  endfunction

  // -----------------------------------------------------------------
  // line conditions
  // -----------------------------------------------------------------
  // only stages 1 and 2 of the scl and sda synchronisers feed logic, only stage 1 of wp
  assign scl_now = cur.scl_sync[1];
  assign scl_was = cur.scl_sync[2];
  assign sda_now = cur.sda_sync[1];
  assign sda_was = cur.sda_sync[2];
  assign wp_now = cur.wp_sync[1];
  assign scl_rise = rising(scl_now, scl_was);
  assign scl_fall = rising(scl_was, scl_now);
  assign start_seen = scl_now & scl_was & rising(sda_was, sda_now);
  assign stop_seen = scl_now & scl_was & rising(sda_now, sda_was);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.scl_sync = {cur.scl_sync[1:0], lk.scl};
    next_cur.sda_sync = {cur.sda_sync[1:0], lk.sda};
    next_cur.wp_sync = {cur.wp_sync[0], wp};
    // self-timed write cycle countdown
    if (cur.busy) begin
      if (cur.wtimer == '0) begin
        next_cur.busy = 1'b0;
      end else begin
        next_cur.wtimer = cur.wtimer - 1'b1;
      end
    end
    if (start_seen) begin
      // any start restarts at control byte
      next_cur.st = seep_pkg::D_CTRL;
      next_cur.cnt = 4'h0;
      next_cur.drv = 1'b0;
      next_cur.armed = 1'b0;
    end else if (stop_seen) begin
      // stop after data starts the cycle
      if (cur.st == seep_pkg::D_WDATA && (|cur.pmask) && !wp_now) begin
        for (int i = 0; i < seep_pkg::PAGE_BYTES; i++) begin
          if (cur.pmask[i]) begin
            next_cur.mem[{cur.ptr[8:4], 4'(i)}] = cur.pbuf[i];
          end
        end
        next_cur.busy = 1'b1;
        next_cur.wtimer = seep_pkg::TMR_W'(WC_CYCLES - 1);
      end
      next_cur.st = seep_pkg::D_IDLE;
      next_cur.drv = 1'b0;
      next_cur.pmask = '0;
    end else if (cur.st != seep_pkg::D_IDLE) begin
      // sample on the high phase of each pulse
      if (scl_rise) begin
        next_cur.armed = 1'b1;
        if (cur.st == seep_pkg::D_RDATA) begin
          if (cur.cnt == seep_pkg::ACK_SLOT) begin
            next_cur.mack = sda_now;
          end
        end else if (cur.cnt != seep_pkg::ACK_SLOT) begin
          next_cur.sh = {cur.sh[6:0], sda_now};
        end
      end
      // the fall that closes a start carries no bit, so it must not count
      if (scl_fall && cur.armed) begin
        unique case (cur.st)
          seep_pkg::D_CTRL, seep_pkg::D_ADDR, seep_pkg::D_WDATA: begin
            if (cur.cnt == seep_pkg::LAST_DATA_BIT) begin
              next_cur.acked = !cur.busy;
              next_cur.cnt = seep_pkg::ACK_SLOT;
              if (cur.st == seep_pkg::D_CTRL) begin
                // other codes leave the bus alone
                next_cur.acked = !cur.busy &&
                  (cur.sh[seep_pkg::TYPE_MSB:seep_pkg::TYPE_LSB] == seep_pkg::DEV_TYPE);
                next_cur.blk = cur.sh[seep_pkg::BLK_BIT];
                next_cur.rd = cur.sh[seep_pkg::RW_BIT];
              end else if (cur.st == seep_pkg::D_ADDR && !cur.busy) begin
                next_cur.ptr = {cur.blk, cur.sh};
                next_cur.pmask = '0;
              end else if (!cur.busy) begin
                // low nibble advances, overwrite in order
                next_cur.pbuf[cur.ptr[3:0]] = cur.sh;
                next_cur.pmask[cur.ptr[3:0]] = 1'b1;
                next_cur.ptr[3:0] = cur.ptr[3:0] + 4'h1;
              end
              // hold sda low over ninth pulse
              next_cur.drv = next_cur.acked;
            end else if (cur.cnt == seep_pkg::ACK_SLOT) begin
              next_cur.cnt = 4'h0;
              next_cur.drv = 1'b0;
              if (!cur.acked) begin
                next_cur.st = seep_pkg::D_IDLE;
              end else if (cur.st == seep_pkg::D_CTRL) begin
                if (cur.rd == seep_pkg::RW_READ) begin
                  next_cur.st = seep_pkg::D_RDATA;
                  next_cur.sh = cur.mem[cur.ptr];
                  next_cur.drv = ~cur.mem[cur.ptr][7];
                end else begin
                  next_cur.st = seep_pkg::D_ADDR;
                end
              end else begin
                next_cur.st = seep_pkg::D_WDATA;
              end
            end else begin
              next_cur.cnt = cur.cnt + 4'h1;
            end
          end
          seep_pkg::D_RDATA: begin
            if (cur.cnt == seep_pkg::LAST_DATA_BIT) begin
              // release for the master's answer
              // nine-bit pointer wraps to zero
              next_cur.cnt = seep_pkg::ACK_SLOT;
              next_cur.drv = 1'b0;
              next_cur.ptr = cur.ptr + 9'h001;
            end else if (cur.cnt == seep_pkg::ACK_SLOT) begin
              if (!cur.mack) begin
                next_cur.cnt = 4'h0;
                next_cur.sh = cur.mem[cur.ptr];
                next_cur.drv = ~cur.mem[cur.ptr][7];
              end else begin
                next_cur.st = seep_pkg::D_IDLE;
              end
            end else begin
              // data moves only while scl is low
              next_cur.cnt = cur.cnt + 4'h1;
              next_cur.sh = {cur.sh[6:0], 1'b0};
              next_cur.drv = ~cur.sh[6];
            end
          end
          default: begin
            next_cur.st = seep_pkg::D_IDLE;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // array contents are cleared at reset, a stand-in for erased cells
  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      cur.st <= seep_pkg::D_IDLE;
      cur.scl_sync <= 3'h7;
      cur.sda_sync <= 3'h7;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  // open drain: pulls low only, enable low while pulling
  assign lk.dev_sda_o = 1'b0;
  assign lk.dev_sda_oe_n = ~cur.drv;
  assign write_busy = cur.busy;
endmodule

// File: seep_host.sv
`timescale 1ns/1ps
module seep_host (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  seep_if.host lk, // two-wire bus
  input wire logic req_valid, // request present
  input wire logic req_write, // 1 byte write, 0 random read
  input wire logic [8:0] req_addr, // array address
  input wire logic [7:0] req_wdata, // byte to write
  output logic req_ready, // idle, request accepted
  output logic done, // one-cycle end of request
  output logic done_nack, // device did not acknowledge
  output logic [7:0] rdata // byte read
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    seep_pkg::seep_hst_e st;
    logic [1:0] sda_sync;
    logic [seep_pkg::QTMR_W-1:0] qtmr;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] rx;
    logic ack_bit;
    logic [1:0] seq;
    logic wr;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic fail;
    logic scl;
    logic drv;
    logic ready;
    logic done;
    logic done_nack;
    logic [7:0] rdata;
  } seep_host_s;

  seep_host_s cur;
  seep_host_s next_cur;
  logic tick;

  // step 3 of a read is the only byte the host receives
  function automatic logic rx_step(input logic [1:0] seq);
    rx_step = (seq == 2'h3);
  endfunction

  assign tick = (cur.qtmr == '0);

  // -----------------------------------------------------------------
  // sequencer, four quarters per bus bit
  // -----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.sda_sync = {cur.sda_sync[0], lk.sda};
    next_cur.done = 1'b0;
    if (cur.st != seep_pkg::H_IDLE) begin
      next_cur.qtmr = tick ? seep_pkg::QTMR_W'(seep_pkg::QTR_CYC - 1) : cur.qtmr - 1'b1;
      if (tick) begin
        next_cur.q = cur.q + 2'h1;
      end
    end
    unique case (cur.st)
      seep_pkg::H_IDLE: begin
        // start only on an idle bus
        if (req_valid && cur.ready && cur.sda_sync[1] && cur.scl) begin
          next_cur.ready = 1'b0;
          next_cur.wr = req_write;
          next_cur.addr = req_addr;
          next_cur.wdata = req_wdata;
          next_cur.seq = 2'h0;
          next_cur.fail = 1'b0;
          next_cur.q = 2'h0;
          next_cur.qtmr = seep_pkg::QTMR_W'(seep_pkg::QTR_CYC - 1);
          next_cur.st = seep_pkg::H_START;
        end
      end
      seep_pkg::H_START: begin
        // host alone makes clock and conditions
        if (tick) begin
          unique case (cur.q)
            2'h0: next_cur.drv = 1'b0;
            2'h1: next_cur.scl = 1'b1;
            2'h2: next_cur.drv = 1'b1;
            default: begin
              next_cur.scl = 1'b0;
              next_cur.bitn = 4'h0;
              // second control byte turns to read
              next_cur.sh = {seep_pkg::DEV_TYPE, 2'h0, cur.addr[8],
                             (cur.seq == 2'h2) ? seep_pkg::RW_READ : seep_pkg::RW_WRITE};
              next_cur.st = seep_pkg::H_BYTE;
            end
          endcase
        end
      end
      seep_pkg::H_BYTE: begin
        if (tick) begin
          unique case (cur.q)
            2'h0: begin
              // data changes only with scl low
              // read byte always answered with nack
              if (cur.bitn == seep_pkg::ACK_SLOT || rx_step(cur.seq)) begin
                next_cur.drv = 1'b0;
              end else begin
                next_cur.drv = ~cur.sh[7];
              end
            end
            2'h1: next_cur.scl = 1'b1;
            2'h2: begin
              if (cur.bitn == seep_pkg::ACK_SLOT) begin
                next_cur.ack_bit = cur.sda_sync[1];
              end else begin
                next_cur.rx = {cur.rx[6:0], cur.sda_sync[1]};
              end
            end
            default: begin
              next_cur.scl = 1'b0;
              if (cur.bitn != seep_pkg::ACK_SLOT) begin
                next_cur.bitn = cur.bitn + 4'h1;
                next_cur.sh = {cur.sh[6:0], 1'b0};
              end else if (rx_step(cur.seq)) begin
                next_cur.rdata = cur.rx;
                next_cur.st = seep_pkg::H_STOP;
              end else if (cur.ack_bit) begin
                // nack while busy, user polls again
                next_cur.fail = 1'b1;
                next_cur.st = seep_pkg::H_STOP;
              end else begin
                next_cur.bitn = 4'h0;
                next_cur.seq = cur.seq + 2'h1;
                if (cur.seq == 2'h0) begin
                  next_cur.sh = cur.addr[7:0];
                end else if (cur.seq == 2'h1 && cur.wr) begin
                  // single byte, never crosses a page
                  next_cur.sh = cur.wdata;
                end else if (cur.seq == 2'h1) begin
                  next_cur.st = seep_pkg::H_START;
                end else begin
                  next_cur.st = cur.wr ? seep_pkg::H_STOP : seep_pkg::H_BYTE;
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          unique case (cur.q)
            2'h0: next_cur.drv = 1'b1;
            2'h1: next_cur.scl = 1'b1;
            2'h2: next_cur.drv = 1'b0;
            default: begin
              next_cur.st = seep_pkg::H_IDLE;
              next_cur.ready = 1'b1;
              next_cur.done = 1'b1;
              next_cur.done_nack = cur.fail;
            end
          endcase
        end
      end
    endcase
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      cur.st <= seep_pkg::H_IDLE;
      cur.scl <= 1'b1;
      cur.sda_sync <= 2'h3;
      cur.ready <= 1'b1;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign lk.scl = cur.scl;
  assign lk.host_sda_o = 1'b0;
  assign lk.host_sda_oe_n = ~cur.drv;
  assign req_ready = cur.ready;
  assign done = cur.done;
  assign done_nack = cur.done_nack;
  assign rdata = cur.rdata;
endmodule

// File: seep_assertions.sv
`timescale 1ns/1ps
module seep_assertions #(
  parameter int unsigned WC_CYCLES = seep_pkg::TWC_CYC // write cycle length in link clocks
) (
  input wire logic clk_link, // device sampling clock
  input wire logic nrst, // async reset, active low
  input wire logic scl, // bus clock
  input wire logic sda, // resolved data line
  input wire logic dev_sda_oe_n, // device pull enable, low pulls
  input wire logic write_busy, // self-timed write running
  input wire logic wp // write protect input
);
  // -----------------------------------------------------------------
  // helper logic
  // -----------------------------------------------------------------
  logic [31:0] busy_cnt;

  // length of the running write cycle, cleared once it ends
  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      busy_cnt <= 32'h0;
    end else if (write_busy) begin
      busy_cnt <= busy_cnt + 32'h1;
    end else begin
      busy_cnt <= 32'h0;
    end
  end

  default clocking cb @(posedge clk_link); endclocking
  default disable iff (!nrst);

  // -----------------------------------------------------------------
  // bus conditions
  // -----------------------------------------------------------------
  sequence seq_start;
    scl && $fell(sda);
  endsequence

  sequence seq_stop;
    scl && $rose(sda);
  endsequence

  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  // device only moves its pull while the clock is low
  a_dev_low_edge: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed sda while scl high");
  // an acknowledge is not dropped during the high time
  a_ack_hold_high: assert property (scl && !dev_sda_oe_n |=> !dev_sda_oe_n || !scl)
    else $error("device released sda during scl high");
  // a busy device never answers anything
  a_busy_no_ack: assert property (write_busy |-> dev_sda_oe_n)
    else $error("device pulled sda while write cycle running");
  // the device stays off sda for eight link clocks after a start
  a_start_dev_quiet: assert property (seq_start |=> dev_sda_oe_n [*8])
    else $error("device pulled sda right after start");
  // a stop leaves the line to the master
  a_stop_dev_quiet: assert property (seq_stop |=> dev_sda_oe_n [*8])
    else $error("device pulled sda right after stop");
  // the write cycle begins only with the bus idle after a stop
  a_busy_after_stop: assert property ($rose(write_busy) |-> scl && sda)
    else $error("write cycle began with bus not idle");
  // protection suppresses the write cycle altogether
  a_busy_wp_low: assert property ($rose(write_busy) |-> !wp)
    else $error("write cycle began while write protected");
  // the self-timed cycle has its fixed length
  a_busy_length: assert property ($fell(write_busy) |-> busy_cnt == WC_CYCLES)
    else $error("write cycle length wrong");

  c_write_cycle: cover property ($rose(write_busy));
endmodule

// File: seep_test.sv
`timescale 1ns/1ps
module seep_test;
  // shortened write cycle, still longer than one polling control byte
  localparam int unsigned WC = 2400;

  logic clk_sys = 1'b0;
  logic clk_link;
  logic nrst;
  logic wp;
  logic req_valid;
  logic req_write;
  logic [8:0] req_addr;
  logic [7:0] req_wdata;
  logic req_ready;
  logic done;
  logic done_nack;
  logic [7:0] rdata;
  logic write_busy;
  int err_count = 0;
  int tests_run = 0;
  int n;

  // -----------------------------------------------------------------
  // clocks, link clock offset so edges never line up
  // -----------------------------------------------------------------
  always #2.5 clk_sys = ~clk_sys;

  initial begin
    clk_link = 1'b0;
    #1.3;
    forever #7.5 clk_link = ~clk_link;
  end

  // -----------------------------------------------------------------
  // both ends joined on one bus
  // -----------------------------------------------------------------
  seep_if bus_if();

  seep_host seep_host_i (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .lk(bus_if), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .done(done),
    .done_nack(done_nack), .rdata(rdata));

  seep_dev #(.WC_CYCLES(WC)) seep_dev_i (.clk_link(clk_link), .nrst(nrst), .ce(1'b1), .lk(bus_if), .wp(wp),
    .write_busy(write_busy));

  seep_assertions #(.WC_CYCLES(WC)) seep_assertions_i (.clk_link(clk_link), .nrst(nrst), .scl(bus_if.scl),
    .sda(bus_if.sda), .dev_sda_oe_n(bus_if.dev_sda_oe_n), .write_busy(write_busy), .wp(wp));

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one request, held until taken, then waits for its done pulse
  task automatic req(input logic wr, input logic [8:0] addr, input logic [7:0] wd);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 1000) begin
      @(negedge clk_sys);
      k++;
    end
    req_write = wr;
    req_addr = addr;
    req_wdata = wd;
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b0 && k < 50) begin
      @(negedge clk_sys);
      k++;
    end
    req_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 40000) begin
      @(negedge clk_sys);
      k++;
    end
    check("done", done, 8'h01);
  endtask

  // -----------------------------------------------------------------
  // hang guard, well above the expected run of some 80k cycles
  // -----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    finish_test;
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    wp = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 9'h000;
    req_wdata = 8'h00;
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    check("scl idle", bus_if.scl, 8'h01);
    check("sda idle", bus_if.sda, 8'h01);
    check("ready", req_ready, 8'h01);
    check("busy reset", write_busy, 8'h00);
    // byte write in the upper block
    req(1'b1, 9'h1A5, 8'h3C);
    check("write nack", done_nack, 8'h00);
    repeat (20) @(negedge clk_sys);
    check("busy after stop", write_busy, 8'h01);
    // polling at once must see no acknowledge
    req(1'b0, 9'h1A5, 8'h00);
    check("poll nack", done_nack, 8'h01);
    n = 0;
    while (write_busy !== 1'b0 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    check("busy end", write_busy, 8'h00);
    // protected write: acknowledged but never committed
    wp = 1'b1;
    repeat (10) @(negedge clk_sys);
    req(1'b1, 9'h1A5, 8'hC3);
    check("wp write nack", done_nack, 8'h00);
    repeat (20) @(negedge clk_sys);
    check("wp no busy", write_busy, 8'h00);
    // reads still served, old data kept
    req(1'b0, 9'h1A5, 8'h00);
    check("read nack", done_nack, 8'h00);
    check("read data", rdata, 8'h3C);
    // same low address, other block untouched
    req(1'b0, 9'h0A5, 8'h00);
    check("block data", rdata, 8'h00);
    finish_test;
  end
endmodule
